// ### spisr_defines.svh
// Register offsets, field positions, reset values, write masks and the bit count per byte of the serial port
`ifndef SPISR_DEFINES_SVH
`define SPISR_DEFINES_SVH

`define SPISR_ADDR_CTRL 2'h0
`define SPISR_ADDR_STAT 2'h1
`define SPISR_ADDR_DATA 2'h2

// Control register fields
`define SPISR_CTL_RXIE 7
`define SPISR_CTL_MSTR 5
`define SPISR_CTL_CLOCK_POLARITY 4
`define SPISR_CTL_CLOCK_PHASE 3
`define SPISR_CTL_WOM 2
`define SPISR_CTL_EN 1
`define SPISR_CTL_TXIE 0
`define SPISR_CTL_RESET 8'h2_8
`define SPISR_CTL_WMASK 8'hb_f

// Status/control register fields
`define SPISR_ST_RXF 7
`define SPISR_ST_ERROR_IRQ_EN 6
`define SPISR_ST_OVR 5
`define SPISR_ST_MODE_FAULT_FLAG 4
`define SPISR_ST_TXE 3
`define SPISR_ST_MODE_FAULT_DETECT_EN 2
`define SPISR_ST_RATE_HI 1
`define SPISR_ST_RATE_LO 0
`define SPISR_ST_WMASK 8'h4_7

`define SPISR_BITS_PER_BYTE 4'h8

`endif

// ### spisr_pkg.sv
// Types shared by the serial port design files
package spisr_pkg;
  typedef logic [7:0] spisr_byte_type;
  typedef logic [1:0] spisr_addr_type;
  typedef logic [1:0] spisr_rate_type;
endpackage

// ### spisr_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module spisr_sync (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_init,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  // Init selects the idle level seen right after reset
  assign o_q = q_r ^ i_init;
endmodule
`default_nettype wire

// ### spisr_baud.sv
// Master serial clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none
module spisr_baud
  import spisr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire spisr_pkg::spisr_rate_type i_rate,
  output logic o_tick
);
  logic [6:0] cnt_r;

  // Half period equals the divisor, so a full clock is 2 x divisor
  function automatic logic [6:0] half_limit(input spisr_rate_type r);
    case (r)
      2'h0: half_limit = 7'h01;
      2'h1: half_limit = 7'h07;
      2'h2: half_limit = 7'h1f;
      default: half_limit = 7'h7f;
    endcase
  endfunction

  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_run || cnt_r >= half_limit(i_rate)) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  assign o_tick = i_run && (cnt_r >= half_limit(i_rate));
endmodule
`default_nettype wire

// ### spisr_top.sv
// Serial peripheral port: registers, master/slave shifter, flags and pin control
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "spisr_defines.svh"

// Functional notes
// - Receive and transmit interrupt enables gate their flags; reset clears both.
// - master_select 1 means master, 0 slave; resets to 1.
// - clock_polarity sets serial clock idle level; resets to 0.
// - clock_phase selects sampling edge timing; resets to 1.
// - wired_or_select makes clock and data pins open-drain, else push-pull.
// - port_enable enables the port; clearing it partially resets; resets to 0.
// - rx_full set on byte arrival; cleared by status read then data read.
// - error_irq_en lets overrun and mode fault request interrupts.
// - Byte arriving while receive full sets overrun; old byte kept.
// - Overrun cleared by status read with flag set then data read.
// - Mode fault: slave select rises mid-byte, or master select low.
// - Mode fault cleared by status read then control write.
// - tx_empty set at handoff to shifter, cleared by data write; resets 1.
// - Detect enable permits mode fault; clearing it keeps the flag.
// - Slave always uses select input; master only with detection enabled.
// - Master without detection ignores select; slave only skips the flag.
// - Rate field picks divisor 2, 8, 32 or 128 in master mode.
// - Serial clock equals base clock over twice the divisor.
// - Data address: writes go to transmit, reads from receive buffer.
// - Deselected slave floats its output and ignores serial clocks.
module spisr_top
  import spisr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire spisr_pkg::spisr_addr_type i_addr,
  input wire spisr_pkg::spisr_byte_type i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output spisr_pkg::spisr_byte_type o_rdata,
  output logic o_irq,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_ssn,
  output logic o_ss_in_use,
  output logic o_pullup_en
);
  import spisr_pkg::*;

  typedef enum logic [2:0] {
    SPISR_IDLE = 3'b001,
    SPISR_LEAD = 3'b010,
    SPISR_TRAIL = 3'b100
  } spisr_state_type;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  spisr_byte_type ctl_r;
  logic err_ie_r, mode_fault_flag_en_r;
  spisr_rate_type rate_r;
  logic rxf_r, ovr_r, mode_fault_flag_r, txe_r;
  logic rxf_armed_r, ovr_armed_r, mode_fault_flag_armed_r;
  spisr_byte_type tx_buf_r, rx_buf_r, shift_r;
  logic [3:0] bit_cnt_r;
  spisr_state_type state_r;
  logic sck_r;
  logic sck_s, sck_q_r, mosi_s, miso_s, ssn_s, ssn_q_r;

  logic en, mstr, clock_polarity, clock_phase, wom;
  logic wr_ctl, wr_st, wr_data, rd_st, rd_data;
  logic tick, load_now, byte_done, sample_in, sck_lead, sck_trail, slv_sel;
  logic slv_busy;
  logic edge_lead, edge_trail, out_r;
  spisr_byte_type rx_word;

  assign en = ctl_r[`SPISR_CTL_EN];
  assign mstr = ctl_r[`SPISR_CTL_MSTR];
  assign clock_polarity = ctl_r[`SPISR_CTL_CLOCK_POLARITY];
  assign clock_phase = ctl_r[`SPISR_CTL_CLOCK_PHASE];
  assign wom = ctl_r[`SPISR_CTL_WOM];
  assign wr_ctl = i_wr && i_addr == `SPISR_ADDR_CTRL;
  assign wr_st = i_wr && i_addr == `SPISR_ADDR_STAT;
  assign wr_data = i_wr && i_addr == `SPISR_ADDR_DATA;
  assign rd_st = i_rd && i_addr == `SPISR_ADDR_STAT;
  assign rd_data = i_rd && i_addr == `SPISR_ADDR_DATA;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  spisr_sync u_sync_sck (.i_clk(i_clk), .i_resetn(i_resetn), .i_init(1'b0),
    .i_d(i_sck), .o_q(sck_s));
  spisr_sync u_sync_mosi (.i_clk(i_clk), .i_resetn(i_resetn), .i_init(1'b0),
    .i_d(i_mosi), .o_q(mosi_s));
  spisr_sync u_sync_miso (.i_clk(i_clk), .i_resetn(i_resetn), .i_init(1'b0),
    .i_d(i_miso), .o_q(miso_s));
  // Select idles high, so reset shows it deselected
  spisr_sync u_sync_ssn (.i_clk(i_clk), .i_resetn(i_resetn), .i_init(1'b1),
    .i_d(~i_ssn), .o_q(ssn_s));

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sck_q_r <= 1'b0;
      ssn_q_r <= 1'b1;
    end else begin
      sck_q_r <= sck_s;
      ssn_q_r <= ssn_s;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctl_r <= `SPISR_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= i_wdata & `SPISR_CTL_WMASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      err_ie_r <= 1'b0;
      mode_fault_flag_en_r <= 1'b0;
      rate_r <= 2'h0;
    end else if (wr_st) begin
      err_ie_r <= i_wdata[`SPISR_ST_ERROR_IRQ_EN];
      mode_fault_flag_en_r <= i_wdata[`SPISR_ST_MODE_FAULT_DETECT_EN];
      rate_r <= i_wdata[`SPISR_ST_RATE_HI:`SPISR_ST_RATE_LO];
    end
  end

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  spisr_baud u_baud (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(en && mstr && state_r != SPISR_IDLE),
    .i_rate(rate_r),
    .o_tick(tick)
  );

  // Slave sees select only as a level; deselect abandons the byte
  assign slv_sel = en && !mstr && !ssn_q_r;
  assign sck_lead = slv_sel && (sck_s != sck_q_r) && (sck_s != clock_polarity);
  assign sck_trail = slv_sel && (sck_s != sck_q_r) && (sck_s == clock_polarity);
  assign slv_busy = !mstr && state_r != SPISR_IDLE;
  assign load_now = en && mstr && state_r == SPISR_IDLE && !txe_r;

  // Sample edge captures a bit, drive edge moves the output bit
  assign sample_in = mstr ? miso_s : mosi_s;
  assign edge_lead = mstr ? tick : sck_lead;
  assign edge_trail = mstr ? tick : sck_trail;
  // Byte always ends on the eighth trailing edge
  assign byte_done = (state_r == SPISR_TRAIL) && edge_trail &&
    (bit_cnt_r == (clock_phase ? `SPISR_BITS_PER_BYTE - 4'h1 : `SPISR_BITS_PER_BYTE));
  // With phase 1 the last bit arrives on the ending edge itself
  assign rx_word = clock_phase ? {shift_r[6:0], sample_in} : shift_r;

  always_ff @(posedge i_clk) begin
    if (!i_resetn || !en || (!mstr && ssn_q_r)) begin
      state_r <= SPISR_IDLE;
      bit_cnt_r <= 4'h0;
      sck_r <= 1'b0;
      shift_r <= 8'h0_0;
      out_r <= 1'b0;
    end else begin
      case (state_r)
        SPISR_IDLE: begin
          sck_r <= 1'b0;
          if (load_now || slv_sel) begin
            shift_r <= tx_buf_r;
            out_r <= tx_buf_r[7];
            bit_cnt_r <= 4'h0;
            state_r <= SPISR_LEAD;
          end
        end
        SPISR_LEAD: begin
          if (edge_lead) begin
            sck_r <= 1'b1;
            if (clock_phase) begin
              out_r <= shift_r[7];
            end else begin
              shift_r <= {shift_r[6:0], sample_in};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            state_r <= SPISR_TRAIL;
          end
        end
        SPISR_TRAIL: begin
          if (edge_trail) begin
            sck_r <= 1'b0;
            if (clock_phase) begin
              shift_r <= {shift_r[6:0], sample_in};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else begin
              out_r <= shift_r[7];
            end
            state_r <= byte_done ? SPISR_IDLE : SPISR_LEAD;
          end
        end
        default: state_r <= SPISR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Transmit buffer and flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tx_buf_r <= 8'h0_0;
    end else if (wr_data) begin
      tx_buf_r <= i_wdata;
    end
  end

  logic handoff;
  assign handoff = state_r == SPISR_IDLE && (load_now || (slv_sel && !txe_r));

  always_ff @(posedge i_clk) begin
    if (!i_resetn || !en) begin
      txe_r <= 1'b1;
    end else if (handoff) begin
      txe_r <= 1'b1;
    end else if (wr_data) begin
      txe_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer, full and overrun
  // ---------------------------------------------------------------
  logic rx_clear;
  assign rx_clear = rd_data && rxf_armed_r;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_buf_r <= 8'h0_0;
    end else if (byte_done && !(rxf_r && !rx_clear)) begin
      rx_buf_r <= rx_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn || !en) begin
      rxf_r <= 1'b0;
      rxf_armed_r <= 1'b0;
      ovr_r <= 1'b0;
      ovr_armed_r <= 1'b0;
    end else begin
      // Set beats a clear in the same cycle
      if (byte_done) begin
        rxf_r <= 1'b1;
      end else if (rx_clear) begin
        rxf_r <= 1'b0;
      end
      if (rd_st) begin
        rxf_armed_r <= rxf_r;
      end else if (rd_data) begin
        rxf_armed_r <= 1'b0;
      end
      if (byte_done && rxf_r && !rx_clear) begin
        ovr_r <= 1'b1;
      end else if (rd_data && ovr_armed_r) begin
        ovr_r <= 1'b0;
      end
      if (rd_st) begin
        ovr_armed_r <= ovr_r;
      end else if (rd_data) begin
        ovr_armed_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode fault
  // ---------------------------------------------------------------
  logic mode_fault_flag_event;
  assign mode_fault_flag_event = en && mode_fault_flag_en_r &&
    ((mstr && !ssn_q_r) || (!mstr && slv_busy && ssn_s && !ssn_q_r));

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mode_fault_flag_r <= 1'b0;
      mode_fault_flag_armed_r <= 1'b0;
    end else begin
      if (mode_fault_flag_event) begin
        mode_fault_flag_r <= 1'b1;
      end else if (wr_ctl && mode_fault_flag_armed_r) begin
        mode_fault_flag_r <= 1'b0;
      end
      if (rd_st) begin
        mode_fault_flag_armed_r <= mode_fault_flag_r;
      end else if (wr_ctl) begin
        mode_fault_flag_armed_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port and interrupt
  // ---------------------------------------------------------------
  spisr_byte_type st_view;
  assign st_view = {rxf_r, err_ie_r, ovr_r, mode_fault_flag_r, txe_r, mode_fault_flag_en_r, rate_r};

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h0_0;
    end else if (i_rd) begin
      case (i_addr)
        `SPISR_ADDR_CTRL: o_rdata <= ctl_r;
        `SPISR_ADDR_STAT: o_rdata <= st_view;
        `SPISR_ADDR_DATA: o_rdata <= rx_buf_r;
        default: o_rdata <= 8'h0_0;
      endcase
    end else begin
      o_rdata <= 8'h0_0;
    end
  end

  assign o_irq = (ctl_r[`SPISR_CTL_RXIE] && rxf_r) ||
    (ctl_r[`SPISR_CTL_TXIE] && txe_r) || (err_ie_r && (ovr_r || mode_fault_flag_r));

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  logic m_drive, s_drive, sck_lvl, out_bit;
  // Mode fault drops master drive to stop bus contention
  assign m_drive = en && mstr && !mode_fault_flag_r;
  assign s_drive = slv_sel;
  assign sck_lvl = sck_r ^ clock_polarity;
  assign out_bit = out_r;
  // Open-drain: only drive low when wired-or
  assign o_sck = sck_lvl;
  assign o_sck_oe = m_drive && (!wom || !sck_lvl);
  assign o_mosi = out_bit;
  assign o_mosi_oe = m_drive && (!wom || !out_bit);
  assign o_miso = out_bit;
  assign o_miso_oe = s_drive && (!wom || !out_bit);
  assign o_pullup_en = en && !wom;
  assign o_ss_in_use = en && (!mstr || mode_fault_flag_en_r);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_st_read_mode_fault_flag;
    rd_st && mode_fault_flag_r;
  endsequence

  a_reset_values: assert property (@(posedge i_clk) $rose(i_resetn) |->
    ctl_r == `SPISR_CTL_RESET && txe_r && !rxf_r)
    else $error("control reset value wrong");
  a_tx_empty_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr_data && !handoff && en |=> !txe_r)
    else $error("tx empty not cleared by data write");
  a_rx_full_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    byte_done && en |=> rxf_r)
    else $error("rx full not set");
  a_overrun_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
    byte_done && rxf_r && !rx_clear |=> ovr_r && $stable(rx_buf_r))
    else $error("overrun handling wrong");
  a_mode_fault_flag_arm: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_st_read_mode_fault_flag |=> mode_fault_flag_armed_r)
    else $error("mode fault clear not armed");
  a_mode_fault_flag_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    mode_fault_flag_armed_r && wr_ctl && !mode_fault_flag_event |=> !mode_fault_flag_r)
    else $error("mode fault not cleared");
  a_mode_fault_flag_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !mode_fault_flag_r && !mode_fault_flag_en_r |=> !mode_fault_flag_r)
    else $error("mode fault set while detection off");
  a_irq_or: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_irq == ((ctl_r[7] && rxf_r) || (ctl_r[0] && txe_r) || (err_ie_r && (ovr_r || mode_fault_flag_r))))
    else $error("interrupt request mismatch");
  a_slave_float: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !mstr && ssn_q_r |-> !o_miso_oe)
    else $error("deselected slave drives output");
  a_disable_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !en |=> state_r == SPISR_IDLE && txe_r)
    else $error("partial reset missing");
endmodule
`default_nettype wire

// ### spisr_peer.sv
// Behavioural peer slave that faces the port when it runs as master
`timescale 1ns/1ps
`default_nettype none
module spisr_peer (
  input wire logic i_sck,
  input wire logic i_ssn,
  input wire logic i_sdi,
  input wire logic i_clock_polarity,
  input wire logic i_clock_phase,
  input wire logic [7:0] i_tx,
  output logic o_sdo,
  output logic [7:0] o_rx
);
  logic [7:0] sh;
  logic lead;
  int ns;
  int nd;
  initial begin
    o_sdo = 1'b1;
    o_rx = 8'h0_0;
    sh = 8'h0_0;
    ns = 0;
    nd = 0;
  end
  // ----------------------------------------
  // Select handling
  // ----------------------------------------
  // Released line shows the inverse, never a stale bit
  always @(i_ssn) begin
    if (i_ssn) begin
      ns = 0;
      nd = 0;
      o_sdo = ~o_sdo;
    end else begin
      o_sdo = i_tx[7];
    end
  end
  // ----------------------------------------
  // Shifting, same polarity and phase as the port
  // ----------------------------------------
  always @(i_sck) begin
    if (!i_ssn) begin
      lead = (i_sck !== i_clock_polarity);
      if (lead ^ i_clock_phase) begin
        sh = {sh[6:0], i_sdi};
        ns++;
        if (ns % 8 == 0) begin
          o_rx = sh;
        end
      end else begin
        nd++;
        o_sdo = i_tx[7 - ((nd - i_clock_phase) & 7)];
      end
    end
  end
endmodule
`default_nettype wire

// ### spisr_top_tb_top.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
`include "spisr_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module spisr_top_tb_top;
  import spisr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  spisr_addr_type addr = 2'h0;
  spisr_byte_type wdata = 8'h0_0;
  spisr_byte_type rdata;
  spisr_byte_type p_tx = 8'h0_0;
  spisr_byte_type p_rx;
  logic m_sck = 1'b0;
  logic m_mosi = 1'b0;
  logic ssn = 1'b1;
  logic p_ssn = 1'b1;
  logic p_clock_polarity = 1'b0;
  logic p_clock_phase = 1'b1;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_use, pu, p_sdo;
  int fails = 0;
  int n_tests = 0;
  wire logic sck_w = sck_oe ? sck_o : m_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : m_mosi;

  always #2.5 clk = ~clk;

  spisr_top dut (.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_sck(sck_w), .o_sck(sck_o),
    .o_sck_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe),
    .i_miso(p_sdo), .o_miso(miso_o), .o_miso_oe(miso_oe), .i_ssn(ssn),
    .o_ss_in_use(ss_use), .o_pullup_en(pu));

  spisr_peer peer (.i_sck(sck_w), .i_ssn(p_ssn), .i_sdi(mosi_w), .i_clock_polarity(p_clock_polarity),
    .i_clock_phase(p_clock_phase), .i_tx(p_tx), .o_sdo(p_sdo), .o_rx(p_rx));

  // ----------------------------------------
  // Register bus and link tasks
  // ----------------------------------------
  task automatic wreg(input spisr_addr_type a, input spisr_byte_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rreg(input spisr_addr_type a, output spisr_byte_type d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Bounded poll; a flag that never rises shows up in the next compare
  task automatic wait_st(input int b, output spisr_byte_type s);
    for (int k = 0; k < 3000; k++) begin
      rreg(`SPISR_ADDR_STAT, s);
      if (s[b] === 1'b1) break;
    end
  endtask

  // Bench as master, polarity 0 and phase 1, well below the sync limit
  task automatic mbyte(input spisr_byte_type t, input int nb, output spisr_byte_type r);
    r = 8'h0_0;
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge clk);
      m_sck <= 1'b1;
      m_mosi <= t[i];
      repeat (16) @(posedge clk);
      m_sck <= 1'b0;
      r[i] = miso_o;
      repeat (16) @(posedge clk);
    end
  endtask

  task automatic half(output int n);
    logic p;
    @(negedge clk);
    p = sck_o;
    for (int k = 0; k < 600 && sck_o === p; k++) @(negedge clk);
    p = sck_o;
    for (n = 0; n < 600 && sck_o === p; n++) @(negedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    spisr_byte_type d;
    rreg(`SPISR_ADDR_CTRL, d); `CHK(d, 8'h2_8);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d, 8'h0_8);
    rreg(2'h3, d); `CHK(d, 8'h0_0);
    `CHK({irq, sck_oe, mosi_oe, miso_oe, pu}, 5'h0_0);
    wreg(`SPISR_ADDR_CTRL, 8'hf_f);
    rreg(`SPISR_ADDR_CTRL, d); `CHK(d, 8'hb_f);
    `CHK(irq, 1'b1);
    `CHK(pu, 1'b0);
    wreg(`SPISR_ADDR_STAT, 8'hf_f);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d, 8'h4_f);
    wreg(`SPISR_ADDR_CTRL, 8'hb_e);
    `CHK(irq, 1'b0);
    wreg(`SPISR_ADDR_CTRL, 8'h2_8);
    $display("reset and register test done");
  endtask

  task automatic t_rate;
    spisr_byte_type d;
    int n;
    int bd[4] = '{2, 8, 32, 128};
    wreg(`SPISR_ADDR_CTRL, 8'h3_a);
    `CHK({sck_o, sck_oe, pu}, 3'b111);
    wreg(`SPISR_ADDR_CTRL, 8'h2_a);
    `CHK(sck_o, 1'b0);
    for (int r = 0; r < 4; r++) begin
      wreg(`SPISR_ADDR_STAT, {6'h0_0, r[1:0]});
      wreg(`SPISR_ADDR_DATA, 8'h8_1);
      half(n); `CHK(n, bd[r]);
      wait_st(7, d);
      rreg(`SPISR_ADDR_DATA, d);
    end
    $display("rate test done");
  endtask

  task automatic t_xfer;
    spisr_byte_type d;
    p_tx <= 8'h3_c;
    p_ssn <= 1'b0;
    wreg(`SPISR_ADDR_CTRL, 8'ha_a);
    wreg(`SPISR_ADDR_STAT, 8'h0_1);
    wreg(`SPISR_ADDR_DATA, 8'ha_5);
    repeat (4) @(posedge clk);
    // Second byte only once the first has moved on
    wreg(`SPISR_ADDR_DATA, 8'h9_6);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d[3], 1'b0);
    wait_st(7, d); `CHK(irq, 1'b1);
    `CHK(p_rx, 8'ha_5);
    wait_st(5, d); `CHK(d[7:3], 5'b10101);
    `CHK(p_rx, 8'h9_6);
    rreg(`SPISR_ADDR_DATA, d); `CHK(d, 8'h3_c);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d[7:5], 3'b000);
    `CHK(irq, 1'b0);
    wreg(`SPISR_ADDR_DATA, 8'h1_1);
    wait_st(7, d);
    wreg(`SPISR_ADDR_CTRL, 8'h2_8);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d, 8'h0_9);
    `CHK({sck_oe, pu}, 2'b00);
    p_ssn <= 1'b1;
    $display("transfer test done");
  endtask

  // Master with phase 0; peer select toggles around the byte
  task automatic t_phase0;
    spisr_byte_type d;
    p_clock_phase <= 1'b0;
    p_tx <= 8'h6_9;
    p_ssn <= 1'b0;
    wreg(`SPISR_ADDR_CTRL, 8'h2_2);
    wreg(`SPISR_ADDR_DATA, 8'hc_6);
    wait_st(7, d);
    rreg(`SPISR_ADDR_DATA, d); `CHK(d, 8'h6_9);
    `CHK(p_rx, 8'hc_6);
    p_ssn <= 1'b1;
    p_clock_phase <= 1'b1;
    wreg(`SPISR_ADDR_CTRL, 8'h2_8);
    $display("phase zero test done");
  endtask

  task automatic t_mode_fault_flag;
    spisr_byte_type d;
    wreg(`SPISR_ADDR_CTRL, 8'h2_a);
    wreg(`SPISR_ADDR_STAT, 8'h4_4);
    `CHK(ss_use, 1'b1);
    ssn <= 1'b0;
    repeat (6) @(posedge clk);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d[4], 1'b1);
    `CHK(irq, 1'b1);
    wreg(`SPISR_ADDR_STAT, 8'h4_0);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d[4], 1'b1);
    wreg(`SPISR_ADDR_CTRL, 8'h2_a);
    rreg(`SPISR_ADDR_STAT, d); `CHK(d[4], 1'b0);
    `CHK({irq, ss_use}, 2'b00);
    ssn <= 1'b1;
    $display("mode fault test done");
  endtask

  task automatic t_slave;
    spisr_byte_type d;
    spisr_byte_type s;
    wreg(`SPISR_ADDR_STAT, 8'h0_0);
    wreg(`SPISR_ADDR_CTRL, 8'h0_a);
    wreg(`SPISR_ADDR_DATA, 8'h5_a);
    `CHK(miso_oe, 1'b0);
    ssn <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({ss_use, miso_oe}, 2'b11);
    mbyte(8'hc_3, 8, d); `CHK(d, 8'h5_a);
    wait_st(7, s);
    rreg(`SPISR_ADDR_DATA, s); `CHK(s, 8'hc_3);
    ssn <= 1'b1;
    mbyte(8'h7_7, 8, d);
    rreg(`SPISR_ADDR_STAT, s); `CHK(s[7], 1'b0);
    wreg(`SPISR_ADDR_STAT, 8'h0_4);
    ssn <= 1'b0;
    repeat (4) @(posedge clk);
    mbyte(8'h0_0, 4, d);
    ssn <= 1'b1;
    repeat (6) @(posedge clk);
    rreg(`SPISR_ADDR_STAT, s); `CHK(s[4], 1'b1);
    $display("slave test done");
  endtask

  // ----------------------------------------
  // Verdict and sequencing
  // ----------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rate();
    t_xfer();
    t_phase0();
    t_mode_fault_flag();
    t_slave();
    conclude();
  end
endmodule
`default_nettype wire
